// ---- shared/machine_check_regs.vh ----
`ifndef MACHINE_CHECK_REGS_VH
`define MACHINE_CHECK_REGS_VH

// Bank count and widths
`define MC_NUM_BANKS        4
`define MC_CODE_W           16
`define MC_COUNT_W          8

// Register byte offsets
`define MC_CAP_OFF          12'h000
`define MC_GSTAT_OFF        12'h004
`define MC_CTRL_OFF         12'h008
`define MC_BANK_BASE        12'h040
`define MC_BANK_STRIDE_LSB  4
`define MC_BANK_STATUS_OFF  2'h0
`define MC_BANK_ADDR_OFF    2'h1
`define MC_BANK_MISC_OFF    2'h2

// Global status fields
`define MC_GS_RESTART_POINTER_VALID_BIT      0
`define MC_GS_ERROR_POINTER_VALID_BIT      1
`define MC_GS_CHECK_IN_PROGRESS_BIT      2
`define MC_GS_SHUT_BIT      3

// Control fields
`define MC_CTRL_EXC_BIT     0
`define MC_CTRL_BANK_LSB    8

// Bank status fields
`define MC_ST_VALID_BIT     31
`define MC_ST_OVER_BIT      30
`define MC_ST_UNCOR_BIT     29
`define MC_ST_MISC_VALID_BIT     28
`define MC_ST_ADDRESS_VALID_BIT     27
`define MC_ST_PCC_BIT       26

// Reset values
`define MC_GSTAT_RST        4'h0
`define MC_CTRL_RST         32'h0000_0000
`define MC_WORD_RST         32'h0000_0000

`endif

// ---- verilog/error_bank.v ----
`timescale 1ns/1ps
`include "machine_check_regs.vh"

module error_bank (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        wr_status,
  input  wire        wr_addr,
  input  wire        wr_misc,
  input  wire [31:0] wdata,
  input  wire        err_valid,
  input  wire        err_uncorrected,
  input  wire        err_context_corrupt,
  input  wire        err_addr_valid,
  input  wire        err_misc_valid,
  input  wire [15:0] err_code,
  input  wire [31:0] err_addr,
  input  wire [31:0] err_misc,
  output reg  [31:0] status_reg,
  output reg  [31:0] addr_reg,
  output reg  [31:0] misc_reg,
  output wire        logged_uncorrected
);

  reg  [31:0] status_base;
  reg  [31:0] status_next;
  reg  [31:0] addr_next;
  reg  [31:0] misc_next;
  reg         take_new;
  wire [31:0] new_status;

  // Fresh status word built from the reported error
  assign new_status = {1'b1, 1'b0, err_uncorrected, err_misc_valid,
                       err_addr_valid, err_context_corrupt, 10'h000,
                       err_code};

  // Every uncorrected report is flagged, even one that does not take the slot
  assign logged_uncorrected = err_valid & err_uncorrected;

  // Software write first, then the error applied on top of the written value
  always @* begin
    status_base = wr_status ? wdata : status_reg;
    addr_next   = wr_addr ? wdata : addr_reg;
    misc_next   = wr_misc ? wdata : misc_reg;
    take_new    = 1'b0;
    status_next = status_base;
    if (err_valid) begin
      // Empty slot, or an uncorrected error displacing a corrected one
      take_new = ~status_base[`MC_ST_VALID_BIT] |
                 (err_uncorrected & ~status_base[`MC_ST_UNCOR_BIT]);
      if (take_new) begin
        status_next = new_status;
        if (err_addr_valid) begin
          addr_next = err_addr;
        end
        if (err_misc_valid) begin
          misc_next = err_misc;
        end
      end
      if (status_base[`MC_ST_VALID_BIT]) begin
        status_next[`MC_ST_OVER_BIT] = 1'b1;
        // Corruption is sticky across displaced errors
        status_next[`MC_ST_PCC_BIT] = status_base[`MC_ST_PCC_BIT] |
                                      err_context_corrupt;
      end
    end
  end

  // Bank storage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= `MC_WORD_RST;
      addr_reg   <= `MC_WORD_RST;
      misc_reg   <= `MC_WORD_RST;
    end else begin
      status_reg <= status_next;
      addr_reg   <= addr_next;
      misc_reg   <= misc_next;
    end
  end

endmodule

// ---- verilog/machine_check_reporting.v ----
// What this block does
// - An enabled uncorrected error raises the exception at once.
// - Corrected errors are only logged, never raising the exception.
// - The count field gives the banks, numbered 0 to count minus one.
// - Each bank status has a valid bit; when clear the rest is void.
// - Context corrupt is set when the processor context was corrupted.
// - Overflow is set when a second error arrives while one is held.
// - Uncorrected is set for an uncorrected error, clear otherwise.
// - Restart pointer valid is set only when resuming is reliable.
// - Error pointer valid is set when the pushed pointer relates.
// - Check in progress set on exception; a second one shuts down.
// - Address and misc valid tell whether those registers hold data.
// - A cleared bank status register records later errors again.
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "machine_check_regs.vh"

module machine_check_reporting (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         hsel,
  input  wire [31:0]  haddr,
  input  wire [1:0]   htrans,
  input  wire         hwrite,
  input  wire [2:0]   hsize,
  input  wire [2:0]   hburst,
  input  wire [3:0]   hprot,
  input  wire         hmastlock,
  input  wire         hready,
  input  wire [31:0]  hwdata,
  output wire         hreadyout,
  output wire         hresp,
  output reg  [31:0]  hrdata,
  input  wire [3:0]   err_valid,
  input  wire [3:0]   err_uncorrected,
  input  wire [3:0]   err_context_corrupt,
  input  wire [3:0]   err_addr_valid,
  input  wire [3:0]   err_misc_valid,
  input  wire [63:0]  err_code,
  input  wire [127:0] err_addr,
  input  wire [127:0] err_misc,
  input  wire         restart_ok,
  input  wire         ip_related,
  output reg          hardware_error_exception,
  output wire         shutdown
);

  localparam NB = `MC_NUM_BANKS;

  // Data phase capture
  reg         dp_write_reg;
  reg  [11:0] dp_addr_reg;
  wire        addr_phase;
  wire        wr_now;

  // Control and global status
  reg  [31:0] ctrl_reg;
  reg         restart_pointer_valid_reg;
  reg         error_pointer_valid_reg;
  reg         check_in_progress_reg;
  reg         shutdown_reg;

  // Bank views
  wire [32*NB-1:0] bank_status;
  wire [32*NB-1:0] bank_addr;
  wire [32*NB-1:0] bank_misc;
  wire [NB-1:0]    bank_uncor;
  wire [NB-1:0]    bank_pcc;
  wire [NB-1:0]    bank_wr_status;
  wire [NB-1:0]    bank_wr_addr;
  wire [NB-1:0]    bank_wr_misc;
  wire [NB-1:0]    bank_enable;
  wire [11:0]      bank_base_w;
  wire [7:0]       bank_row;

  wire        raise;
  wire        any_pcc;
  wire        gstat_wr;
  reg  [31:0] rdata_next;
  reg  [31:0] bank_word;
  integer     idx;

  // Zero wait state slave, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_now     = dp_write_reg;
  assign bank_enable = ctrl_reg[`MC_CTRL_BANK_LSB +: NB];
  // Row index of bank zero in the address map
  assign bank_base_w = `MC_BANK_BASE;
  assign bank_row    = bank_base_w[11:`MC_BANK_STRIDE_LSB];

  // Address phase sampled into data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 12'h000;
    end else if (hready) begin
      dp_write_reg <= addr_phase & hwrite;
      dp_addr_reg  <= haddr[11:0];
    end
  end

  // Per bank write strobes and error reporters
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi = gi + 1) begin : g_bank
      localparam [7:0] IDX = gi;
      wire        hit;
      assign hit  = wr_now &
                    (dp_addr_reg[11:`MC_BANK_STRIDE_LSB] ==
                     bank_row + IDX) &
                    (dp_addr_reg[1:0] == 2'h0);
      assign bank_wr_status[gi] = hit &
        (dp_addr_reg[3:2] == `MC_BANK_STATUS_OFF);
      assign bank_wr_addr[gi] = hit &
        (dp_addr_reg[3:2] == `MC_BANK_ADDR_OFF);
      assign bank_wr_misc[gi] = hit &
        (dp_addr_reg[3:2] == `MC_BANK_MISC_OFF);
      // Disabled banks report nothing
      assign bank_pcc[gi] = err_valid[gi] & bank_enable[gi] &
                            err_context_corrupt[gi];

      error_bank u_bank (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .wr_status           (bank_wr_status[gi]),
        .wr_addr             (bank_wr_addr[gi]),
        .wr_misc             (bank_wr_misc[gi]),
        .wdata               (hwdata),
        .err_valid           (err_valid[gi] & bank_enable[gi]),
        .err_uncorrected     (err_uncorrected[gi]),
        .err_context_corrupt (err_context_corrupt[gi]),
        .err_addr_valid      (err_addr_valid[gi]),
        .err_misc_valid      (err_misc_valid[gi]),
        .err_code            (err_code[16*gi +: 16]),
        .err_addr            (err_addr[32*gi +: 32]),
        .err_misc            (err_misc[32*gi +: 32]),
        .status_reg          (bank_status[32*gi +: 32]),
        .addr_reg            (bank_addr[32*gi +: 32]),
        .misc_reg            (bank_misc[32*gi +: 32]),
        .logged_uncorrected  (bank_uncor[gi])
      );
    end
  endgenerate

  // Only uncorrected errors with the exception enabled raise it
  assign raise = (|bank_uncor) &
                 ctrl_reg[`MC_CTRL_EXC_BIT];
  assign any_pcc  = |bank_pcc;
  assign gstat_wr = wr_now & (dp_addr_reg == `MC_GSTAT_OFF);
  assign shutdown = shutdown_reg;

  // Control register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `MC_CTRL_RST;
    end else if (wr_now && dp_addr_reg == `MC_CTRL_OFF) begin
      ctrl_reg <= hwdata;
    end
  end

  // Global status; an exception in the same cycle wins over a write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restart_pointer_valid_reg                 <= 1'b0;
      error_pointer_valid_reg                 <= 1'b0;
      check_in_progress_reg                 <= 1'b0;
      shutdown_reg             <= 1'b0;
      hardware_error_exception <= 1'b0;
    end else begin
      hardware_error_exception <= 1'b0;
      if (gstat_wr) begin
        restart_pointer_valid_reg <= hwdata[`MC_GS_RESTART_POINTER_VALID_BIT];
        error_pointer_valid_reg <= hwdata[`MC_GS_ERROR_POINTER_VALID_BIT];
        check_in_progress_reg <= hwdata[`MC_GS_CHECK_IN_PROGRESS_BIT];
      end
      if (raise && !shutdown_reg) begin
        if (check_in_progress_reg) begin
          shutdown_reg <= 1'b1;
        end else begin
          hardware_error_exception <= 1'b1;
          check_in_progress_reg <= 1'b1;
          restart_pointer_valid_reg <= restart_ok & ~any_pcc;
          error_pointer_valid_reg <= ip_related;
        end
      end
    end
  end

  // Bank word select for reads
  always @* begin
    bank_word = 32'h0000_0000;
    for (idx = 0; idx < NB; idx = idx + 1) begin
      if (haddr[11:`MC_BANK_STRIDE_LSB] ==
          idx[7:0] + bank_row) begin
        case (haddr[3:2])
          `MC_BANK_STATUS_OFF: bank_word = bank_status[32*idx +: 32];
          `MC_BANK_ADDR_OFF:   bank_word = bank_addr[32*idx +: 32];
          `MC_BANK_MISC_OFF:   bank_word = bank_misc[32*idx +: 32];
          default:             bank_word = 32'h0000_0000;
        endcase
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_next = 32'h0000_0000;
    case (haddr[11:0])
      `MC_CAP_OFF:   rdata_next = NB;
      `MC_GSTAT_OFF: begin
        rdata_next[`MC_GS_RESTART_POINTER_VALID_BIT] = restart_pointer_valid_reg;
        rdata_next[`MC_GS_ERROR_POINTER_VALID_BIT] = error_pointer_valid_reg;
        rdata_next[`MC_GS_CHECK_IN_PROGRESS_BIT] = check_in_progress_reg;
        rdata_next[`MC_GS_SHUT_BIT] = shutdown_reg;
      end
      `MC_CTRL_OFF:  rdata_next = ctrl_reg;
      default:       rdata_next = bank_word;
    endcase
    if (haddr[1:0] != 2'h0) begin
      rdata_next = 32'h0000_0000;
    end
  end

  // Read data registered at the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

endmodule

// ---- testbench/machine_check_reporting_props.sv ----
`timescale 1ns/1ps
module machine_check_reporting_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire        hready,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire [3:0]  err_valid,
  input wire [3:0]  err_uncorrected,
  input wire        hardware_error_exception,
  input wire        shutdown
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Any uncorrected report, and a read address phase
  wire unc = |(err_valid & err_uncorrected);
  wire rd  = hsel & hready & htrans[1] & ~hwrite;
  exc_cause_a: assert property (
      hardware_error_exception |-> $past(unc))
    else $error("exception with no uncorrected report");
  exc_pulse_a: assert property (
      hardware_error_exception |=> !hardware_error_exception)
    else $error("exception longer than one cycle");
  corr_quiet_a: assert property (
      !unc |=> !hardware_error_exception)
    else $error("exception for corrected error");
  shut_hold_a: assert property (shutdown |=> shutdown)
    else $error("shutdown dropped");
  shut_cause_a: assert property (
      $rose(shutdown) |-> $past(unc))
    else $error("shutdown with no uncorrected report");
  shut_mute_a: assert property (
      shutdown |=> !hardware_error_exception [*4])
    else $error("exception during shutdown");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rdata_hold_a: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved without a read");
  cover property (hardware_error_exception);
  cover property ($rose(shutdown));
  cover property (rd);
endmodule

// ---- testbench/machine_check_reporting_tb_top.sv ----
`timescale 1ns/1ps
module machine_check_reporting_tb_top;
  reg          hclk, hresetn, hsel, hwrite, restart_ok, ip_related;
  reg  [31:0]  haddr, hwdata, rv;
  reg  [1:0]   htrans;
  reg  [3:0]   err_valid, err_uncorrected, err_context_corrupt;
  reg  [3:0]   err_addr_valid, err_misc_valid;
  reg  [63:0]  err_code;
  reg  [127:0] err_addr;
  wire         hreadyout, hresp, hardware_error_exception, shutdown;
  wire [31:0]  hrdata;
  integer      miscompares, compares, cycles;
  machine_check_reporting dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hburst(3'h0), .hprot(4'h3), .hmastlock(1'b0),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .err_valid(err_valid),
    .err_uncorrected(err_uncorrected),
    .err_context_corrupt(err_context_corrupt),
    .err_addr_valid(err_addr_valid), .err_misc_valid(err_misc_valid),
    .err_code(err_code), .err_addr(err_addr), .err_misc(err_addr),
    .restart_ok(restart_ok), .ip_related(ip_related),
    .hardware_error_exception(hardware_error_exception),
    .shutdown(shutdown));
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      test_done;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // One single transfer; read data lands in rv
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
    end
  endtask
  task rd_chk(input [31:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(rv, exp);
    end
  endtask
  // One-cycle report on bank b, then exception pulse check
  task err(input [1:0] b, input u, input p, input av, input mv,
           input [15:0] c, input [31:0] ad, input e);
    begin
      @(posedge hclk);
      err_valid <= 4'h1 << b;
      err_uncorrected <= {4{u}};
      err_context_corrupt <= {4{p}};
      err_addr_valid <= {4{av}};
      err_misc_valid <= {4{mv}};
      err_code <= {4{c}};
      err_addr <= {4{ad}};
      @(posedge hclk);
      err_valid <= 4'h0;
      @(negedge hclk);
      chk({31'h0, hardware_error_exception}, {31'h0, e});
      @(negedge hclk);
      chk({31'h0, hardware_error_exception}, 32'h0);
    end
  endtask
  task s_reset_map;
    begin
      rd_chk(32'h000, 32'h4);
      rd_chk(32'h070, 32'h0);
      rd_chk(32'hffc, 32'h0);
      rd_chk(32'h004, 32'h0);
    end
  endtask
  task s_exc_off;
    begin
      bus(1'b1, 32'h008, 32'h0000_0f00);
      err(2, 1, 0, 0, 0, 16'h0002, 32'h0, 0);
      rd_chk(32'h060, 32'ha000_0002);
    end
  endtask
  task s_corrected;
    begin
      bus(1'b1, 32'h008, 32'h0000_0f01);
      err(0, 0, 0, 1, 0, 16'h1234, 32'h1111_0000, 0);
      rd_chk(32'h040, 32'h8800_1234);
      rd_chk(32'h044, 32'h1111_0000);
      err(0, 0, 0, 0, 0, 16'h5678, 32'h0, 0);
      rd_chk(32'h040, 32'hc800_1234);
    end
  endtask
  task s_uncorrected;
    begin
      restart_ok <= 1'b1;
      ip_related <= 1'b1;
      err(1, 1, 1, 0, 1, 16'h00bb, 32'hcafe_0001, 1);
      rd_chk(32'h050, 32'hb400_00bb);
      rd_chk(32'h058, 32'hcafe_0001);
      rd_chk(32'h004, 32'h6);
    end
  endtask
  task s_relog;
    begin
      bus(1'b1, 32'h004, 32'h0);
      bus(1'b1, 32'h040, 32'h0);
      rd_chk(32'h040, 32'h0);
      err(0, 0, 0, 0, 0, 16'h00ab, 32'h0, 0);
      rd_chk(32'h040, 32'h8000_00ab);
      ip_related <= 1'b0;
      err(3, 1, 0, 0, 0, 16'h0003, 32'h0, 1);
      rd_chk(32'h004, 32'h5);
    end
  endtask
  task s_nested;
    begin
      err(3, 1, 0, 0, 0, 16'h0004, 32'h0, 0);
      chk({31'h0, shutdown}, 32'h1);
      rd_chk(32'h004, 32'hd);
      err(1, 1, 0, 0, 0, 16'h0005, 32'h0, 0);
      chk({31'h0, shutdown}, 32'h1);
    end
  endtask
  // Reset, then the scenarios in order
  initial begin
    miscompares = 0;
    compares = 0;
    cycles = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    restart_ok = 1'b0;
    ip_related = 1'b0;
    err_valid = 4'h0;
    err_uncorrected = 4'h0;
    err_context_corrupt = 4'h0;
    err_addr_valid = 4'h0;
    err_misc_valid = 4'h0;
    err_code = 64'h0;
    err_addr = 128'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    s_reset_map;
    s_exc_off;
    s_corrected;
    s_uncorrected;
    s_relog;
    s_nested;
    test_done;
  end
endmodule
bind machine_check_reporting machine_check_reporting_props u_props (
  .hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .hreadyout,
  .hresp, .hrdata, .err_valid, .err_uncorrected,
  .hardware_error_exception, .shutdown);
